// >>> bench/dpt_pin_model.sv
// Far-side model of the shared capture and complement pin
`timescale 1ns/1ps
`default_nettype none
module dpt_pin_model
(
    // Level the external source wants on the pin
    input wire logic drive_lvl,
    // Timer side of the pin
    input wire logic tout_n,
    input wire logic tout_n_oe,
    // Resolved pin level
    output logic pin
);
    // timer owns the pin when its enable is high
    assign pin = tout_n_oe ? tout_n : drive_lvl;
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench of the dual PWM and capture timer
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    dpt_pkg::dpt_apb_req_t apb_req = '0;
    dpt_pkg::dpt_apb_rsp_t apb_rsp;
    logic tin;
    logic tout;
    logic tout_n;
    logic tout_n_oe;
    logic timer_irq;
    logic drive_lvl = 1'b0;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h0000000e;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_irq = 0;
    int t_last = 0;
    int t_prev = 0;
    int hp = 0;
    int hn = 0;
    int hp_l = 0;
    int hp_p = 0;
    int hn_l = 0;
    int hn_p = 0;
    int both = 0;
    int t_en;
    int ten;
    int base;
    int b0;
    int p;
    int hi;

    always #4 ref_clk = ~ref_clk;

    dpt_timer dpt_timer_inst (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .tin(tin), .tout(tout), .tout_n(tout_n),
        .tout_n_oe(tout_n_oe), .timer_irq(timer_irq));
    dpt_pin_model dpt_pin_model_inst (.drive_lvl(drive_lvl), .tout_n(tout_n),
        .tout_n_oe(tout_n_oe), .pin(tin));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] expv);
        int i;
        @(posedge ref_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        if (!wr)
            exp_q.push_back(expv);
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (apb_rsp.pready !== 1'b1 && i < 50);
        if (i >= 50)
            check("apb_ready", 33'h0, 33'h1);
        t_en = cyc;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic wait_irq(input int n);
        int i;
        i = 0;
        while (n_irq < n && i < 5000)
        begin
            @(posedge ref_clk);
            i++;
        end
        if (n_irq < n)
            check("irq_wait", 33'h0, 33'h1);
    endtask

    // ------------------------------------------------------------------
    // Watchers
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (apb_rsp.pready === 1'b1 && apb_req.psel && !apb_req.pwrite && exp_q.size() > 0)
            check("apb_read", {apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
    end

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        hp <= hp + int'(tout === 1'b1);
        hn <= hn + int'(tout_n === 1'b1);
        if (tout === 1'b1 && tout_n === 1'b1)
            both <= both + 1;
        if (timer_irq === 1'b1)
        begin
            n_irq <= n_irq + 1;
            t_prev <= t_last;
            t_last <= cyc;
            hp_p <= hp_l;
            hp_l <= hp;
            hn_p <= hn_l;
            hn_l <= hn;
        end
    end

    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`DPT_OFS_CTL0, 32'h0);
        rd(`DPT_OFS_CTL1, 32'h0);
        rd(`DPT_OFS_COUNT, 32'h1);
        rd(`DPT_OFS_PWM, 32'h0);
        rd(`DPT_OFS_RELOAD, 32'hffff);
        rd(`DPT_OFS_DBAND, 32'h0);
        apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
        for (int pol = 0; pol < 2; pol++)
        begin
            drive_lvl <= 1'b0;
            wr(`DPT_OFS_CTL0, 32'(pol * 64) + 32'h3b);
            wr(`DPT_OFS_CTL1, 32'h0);
            wr(`DPT_OFS_COUNT, 32'h1);
            wr(`DPT_OFS_RELOAD, 32'h3);
            wr(`DPT_OFS_PWM, 32'h0);
            wr(`DPT_OFS_CTL0, 32'(pol * 64) + 32'hbb);
            ten = t_en;
            base = n_irq;
            if (pol == 1)
            begin
                drive_lvl <= 1'b1;
                repeat (12) @(posedge ref_clk);
                check("wrong_edge", 33'(n_irq), 33'(base));
            end
            drive_lvl <= (pol == 0);
            wait_irq(base + 1);
            rd(`DPT_OFS_CTL1, 32'h2);
            rd(`DPT_OFS_PWM, 32'h1);
            wait_irq(base + 2);
            check("reload_time", 33'(t_last - ten >= 384 && t_last - ten <= 388), 33'h1);
            rd(`DPT_OFS_CTL1, 32'h0);
            rd(`DPT_OFS_PWM, 32'h1);
            wr(`DPT_OFS_CTL0, 32'h0);
        end
        wr(`DPT_OFS_CTL0, 32'h88);
        repeat (4) @(posedge ref_clk);
        check("oe_no_high_bit", 33'(tout_n_oe), 33'h0);
        for (int pol = 0; pol < 2; pol++)
        begin
            seed = xs(seed);
            p = 4 + int'(seed[2:0]);
            wr(`DPT_OFS_CTL0, 32'(pol * 64) + 32'h08);
            wr(`DPT_OFS_CTL1, 32'h1);
            wr(`DPT_OFS_COUNT, 32'hf);
            wr(`DPT_OFS_PWM, 32'(p));
            wr(`DPT_OFS_DBAND, 32'(2 + pol));
            wr(`DPT_OFS_RELOAD, 32'h14);
            repeat (4) @(posedge ref_clk);
            check("idle_level", 33'(tout), 33'(pol));
            base = n_irq;
            b0 = both;
            wr(`DPT_OFS_CTL0, 32'(pol * 64) + 32'h88);
            ten = t_en;
            wait_irq(base + 1);
            check("first_pass", 33'(t_last - ten >= 12 && t_last - ten <= 16), 33'h1);
            wait_irq(base + 4);
            check("period", 33'(t_last - t_prev), 33'd40);
            hi = (pol == 1) ? 2 * p : 2 * (20 - p);
            check("tout_high", 33'(hp_l - hp_p), 33'(hi - 2 - pol));
            check("tout_n_high", 33'(hn_l - hn_p), 33'(40 - hi - 2 - pol));
            check("overlap", 33'(both - b0), 33'h0);
            check("pin_owner", 33'(tout_n_oe), 33'h1);
            wr(`DPT_OFS_CTL0, 32'h0);
        end
        final_report();
    end
endmodule
`default_nettype wire

// >>> design/dpt_deadband.sv
// Complementary output pair with deadband after every transition
`timescale 1ns/1ps
`default_nettype none
module dpt_deadband
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Waveform and delay
    input wire logic raw,
    input wire logic [7:0] dband,
    // Outputs
    output logic out_p,
    output logic out_n
);
    dpt_pkg::dpt_db_st_t st;
    dpt_pkg::dpt_db_st_t next_st;

    // ------------------------------------------------------------------
    // Deadband
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.prev = raw;
        if (raw != st.prev)
        begin
            next_st.cnt = dband;
        end
        else if (st.cnt != 8'h00)
        begin
            next_st.cnt = st.cnt - 8'h01;
        end
        if (raw != st.prev ? dband != 8'h00 : st.cnt > 8'h01)
        begin
            next_st.out_p = 1'b0;
            next_st.out_n = 1'b0;
        end
        else
        begin
            next_st.out_p = raw;
            next_st.out_n = ~raw;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            st <= '0;
        else
            st <= next_st;
    end

    assign out_p = st.out_p;
    assign out_n = st.out_n;

    sequence s_edge_db;
        (raw != st.prev) && dband == 8'h02;
    endsequence

    AST_DEADBAND: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_edge_db |=> (!out_p && !out_n) [*2])
        else $error("deadband outputs not both inactive");
endmodule
`default_nettype wire

// >>> design/dpt_pkg.sv
// Types shared by the dual PWM and capture timer
`default_nettype none
package dpt_pkg;

    typedef enum logic [1:0] {DPT_CONT, DPT_CAPTURE, DPT_DUAL_PWM} dpt_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dpt_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dpt_apb_rsp_t;

    typedef struct packed {
        logic en;
        logic pol;
        logic [2:0] presc;
        logic [2:0] mode;
        logic mode_hi;
        logic cap_flag;
        logic [15:0] count;
        logic [15:0] pwm;
        logic [15:0] reload;
        logic [7:0] dband;
        logic [2:0] tin_sync;
        logic irq;
        logic pin_oe;
        dpt_apb_rsp_t rsp;
    } dpt_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } dpt_presc_st_t;

    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
        logic out_p;
        logic out_n;
    } dpt_db_st_t;

endpackage
`default_nettype wire

// >>> design/dpt_prescaler.sv
// Prescaler giving one tick every 2**presc system clocks
`timescale 1ns/1ps
`default_nettype none
module dpt_prescaler
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic [2:0] presc,
    // Tick
    output logic tick
);
    dpt_pkg::dpt_presc_st_t st;
    dpt_pkg::dpt_presc_st_t next_st;
    logic [6:0] last;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        last = 7'((8'h01 << presc) - 8'h01);
        next_st.tick = 1'b0;
        if (!run)
        begin
            next_st.cnt = 7'h00;
        end
        else if (st.cnt >= last)
        begin
            next_st.cnt = 7'h00;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;

    AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (!rstn)
        (tick && run && presc == 3'h1) |=> !tick ##1 (tick || !run || presc != 3'h1))
        else $error("prescaler tick spacing wrong");
endmodule
`default_nettype wire

// >>> design/dpt_regs.svh
// Register offsets, field positions, reset values and mode codes of the timer
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DPT_OFS_CTL0 12'h000
`define DPT_OFS_CTL1 12'h004
`define DPT_OFS_COUNT 12'h008
`define DPT_OFS_PWM 12'h00c
`define DPT_OFS_RELOAD 12'h010
`define DPT_OFS_DBAND 12'h014

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DPT_CTL0_EN 7
`define DPT_CTL0_POL 6
`define DPT_CTL0_PRESC_HI 5
`define DPT_CTL0_PRESC_LO 3
`define DPT_CTL0_MODE_HI 2
`define DPT_CTL0_MODE_LO 0
`define DPT_CTL1_MODEHI 0
`define DPT_CTL1_CAPFLAG 1

// ----------------------------------------------------------------------
// Mode codes of {mode_high_select_bit, mode}
// ----------------------------------------------------------------------
`define DPT_CODE_CAPTURE 4'h3
`define DPT_CODE_DUAL_PWM 4'h8

// ----------------------------------------------------------------------
// Reset and restart values
// ----------------------------------------------------------------------
`define DPT_RESTART 16'h0001
`define DPT_RST_COUNT 16'h0001
`define DPT_RST_PWM 16'h0000
`define DPT_RST_RELOAD 16'hffff
`define DPT_RST_DBAND 8'h00

`endif

// >>> design/dpt_timer.sv
// Dual PWM and capture timer with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "dpt_regs.svh"
module dpt_timer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire dpt_pkg::dpt_apb_req_t apb_req,
    output dpt_pkg::dpt_apb_rsp_t apb_rsp,
    // Timer pins
    input wire logic tin,
    output logic tout,
    output logic tout_n,
    output logic tout_n_oe,
    // Interrupt request pulse
    output logic timer_irq
);
    dpt_pkg::dpt_state_t st;
    dpt_pkg::dpt_state_t next_st;
    dpt_pkg::dpt_mode_t mode;
    logic tick;
    logic raw;
    logic at_reload;
    logic cap_evt;
    logic access;
    logic done;
    logic wr_count;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    function automatic dpt_pkg::dpt_mode_t decode_mode(input logic hi, input logic [2:0] m);
        case ({hi, m})
            `DPT_CODE_CAPTURE: decode_mode = dpt_pkg::DPT_CAPTURE;
            `DPT_CODE_DUAL_PWM: decode_mode = dpt_pkg::DPT_DUAL_PWM;
            default: decode_mode = dpt_pkg::DPT_CONT;
        endcase
    endfunction

    assign mode = decode_mode(st.mode_hi, st.mode);

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    dpt_prescaler u_presc
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(st.en),
        .presc(st.presc),
        .tick(tick)
    );

    assign raw = (st.en && mode == dpt_pkg::DPT_DUAL_PWM) ? ((st.count > st.pwm) ^ st.pol)
                                                          : st.pol;

    dpt_deadband u_db
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .raw(raw),
        .dband(st.dband),
        .out_p(tout),
        .out_n(tout_n)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign at_reload = st.count == st.reload;
    assign access = apb_req.psel && apb_req.penable;
    assign done = access && st.rsp.pready;
    assign wr_count = done && apb_req.pwrite && apb_req.paddr == `DPT_OFS_COUNT;
    assign cap_evt = st.en && mode == dpt_pkg::DPT_CAPTURE &&
                     (st.pol ? (!st.tin_sync[1] && st.tin_sync[2])
                             : (st.tin_sync[1] && !st.tin_sync[2]));

    always_comb
    begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.tin_sync = {st.tin_sync[1:0], tin};
        next_st.pin_oe = mode == dpt_pkg::DPT_DUAL_PWM;

        if (st.en && tick)
        begin
            if (at_reload)
            begin
                next_st.count = `DPT_RESTART;
                next_st.irq = 1'b1;
                if (mode == dpt_pkg::DPT_CAPTURE)
                    next_st.cap_flag = 1'b0;
            end
            else
            begin
                next_st.count = st.count + 16'h0001;
            end
        end

        // APB response one cycle into access phase
        next_st.rsp.pready = access && !st.rsp.pready;
        next_st.rsp.pslverr = 1'b0;
        if (access && !st.rsp.pready)
        begin
            next_st.rsp.prdata = 32'h0000_0000;
            case (apb_req.paddr)
                `DPT_OFS_CTL0:
                    next_st.rsp.prdata[7:0] = {st.en, st.pol, st.presc, st.mode};
                `DPT_OFS_CTL1:
                    next_st.rsp.prdata[1:0] = {st.cap_flag, st.mode_hi};
                `DPT_OFS_COUNT: next_st.rsp.prdata[15:0] = st.count;
                `DPT_OFS_PWM: next_st.rsp.prdata[15:0] = st.pwm;
                `DPT_OFS_RELOAD: next_st.rsp.prdata[15:0] = st.reload;
                `DPT_OFS_DBAND: next_st.rsp.prdata[7:0] = st.dband;
                default: next_st.rsp.pslverr = 1'b1;
            endcase
        end

        // Writes take effect at the edge that completes the access
        if (done && apb_req.pwrite)
        begin
            case (apb_req.paddr)
                `DPT_OFS_CTL0:
                begin
                    next_st.en = apb_req.pwdata[`DPT_CTL0_EN];
                    next_st.pol = apb_req.pwdata[`DPT_CTL0_POL];
                    next_st.presc = apb_req.pwdata[`DPT_CTL0_PRESC_HI:`DPT_CTL0_PRESC_LO];
                    next_st.mode = apb_req.pwdata[`DPT_CTL0_MODE_HI:`DPT_CTL0_MODE_LO];
                end
                `DPT_OFS_CTL1:
                begin
                    next_st.mode_hi = apb_req.pwdata[`DPT_CTL1_MODEHI];
                    if (!apb_req.pwdata[`DPT_CTL1_CAPFLAG])
                        next_st.cap_flag = 1'b0;
                end
                `DPT_OFS_COUNT: next_st.count = apb_req.pwdata[15:0];
                `DPT_OFS_PWM: next_st.pwm = apb_req.pwdata[15:0];
                `DPT_OFS_RELOAD: next_st.reload = apb_req.pwdata[15:0];
                `DPT_OFS_DBAND: next_st.dband = apb_req.pwdata[7:0];
                default: next_st.en = st.en;
            endcase
        end

        if (cap_evt)
        begin
            next_st.pwm = st.count;
            next_st.cap_flag = 1'b1;
            next_st.irq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.count <= `DPT_RST_COUNT;
            st.pwm <= `DPT_RST_PWM;
            st.reload <= `DPT_RST_RELOAD;
            st.dband <= `DPT_RST_DBAND;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign apb_rsp = st.rsp;
    assign tout_n_oe = st.pin_oe;
    assign timer_irq = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_pwm_wrap;
        st.en && tick && at_reload && mode == dpt_pkg::DPT_DUAL_PWM && !wr_count;
    endsequence

    sequence s_capture;
        cap_evt && !wr_count;
    endsequence

    AST_PWM_RESTART: assert property (s_pwm_wrap |=> st.count == 16'h0001)
        else $error("PWM pass did not restart at one");

    AST_ADVANCE: assert property ((st.en && tick && !at_reload && !wr_count)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("counter did not advance on tick");

    AST_IDLE_HOLD: assert property ((!st.en && !wr_count) |=> st.count == $past(st.count))
        else $error("counter moved while disabled");

    AST_PIN_ROLE: assert property ((mode == dpt_pkg::DPT_DUAL_PWM) ##1
        (mode == dpt_pkg::DPT_DUAL_PWM) |-> tout_n_oe)
        else $error("complement pin not driven in dual PWM");

    AST_CAP_COPY: assert property (s_capture |=> st.pwm == $past(st.count))
        else $error("capture did not copy count");

    AST_CAP_FLAG: assert property (s_capture |=> st.cap_flag && timer_irq)
        else $error("capture flag or interrupt missing");

    AST_CAP_KEEP: assert property ((s_capture and (st.en && !tick))
        |=> st.count == $past(st.count) && st.en)
        else $error("capture disturbed counting");

    AST_RLD_CLEAR: assert property ((st.en && tick && at_reload &&
        mode == dpt_pkg::DPT_CAPTURE && !cap_evt && !done) |=> !st.cap_flag && timer_irq)
        else $error("reload did not clear capture flag");

    // ------------------------------------------------------------------
    // Output, pin, capture, count load and prescaler checks
    // ------------------------------------------------------------------
    sequence s_raw_edge;
        $changed(raw) && st.dband == 8'h03;
    endsequence

    sequence s_gap3;
        (!tout && !tout_n) [*3];
    endsequence

    sequence s_wrong_edge;
        st.en && mode == dpt_pkg::DPT_CAPTURE && (st.tin_sync[1] != st.tin_sync[2]) &&
            (st.tin_sync[1] == st.pol) && !(tick && at_reload);
    endsequence

    AST_GAP_THREE: assert property (s_raw_edge |=> s_gap3)
        else $error("deadband gap shorter than three clocks");

    AST_OUT_EXCL: assert property (!(tout && tout_n))
        else $error("both complementary outputs high");

    AST_WRONG_EDGE: assert property (s_wrong_edge |=> !timer_irq)
        else $error("capture on the unselected edge");

    AST_PWM_IRQ: assert property (s_pwm_wrap |=> timer_irq)
        else $error("PWM wrap without interrupt");

    AST_CAP_RELOAD: assert property ((st.en && tick && at_reload && !wr_count &&
        mode == dpt_pkg::DPT_CAPTURE) |=> timer_irq && st.count == 16'h0001)
        else $error("capture mode did not wrap at reload");

    AST_COUNT_LOAD: assert property (wr_count
        |=> st.count == 16'($past(apb_req.pwdata)))
        else $error("start count not loaded");

    AST_TICK_IDLE: assert property (!st.en |=> !tick)
        else $error("prescaler ticked while disabled");

    AST_PIN_FREE: assert property ((mode != dpt_pkg::DPT_DUAL_PWM) ##1
        (mode != dpt_pkg::DPT_DUAL_PWM) |-> !tout_n_oe)
        else $error("complement pin driven outside dual PWM");

    AST_PWM_NO_CAP: assert property ((mode == dpt_pkg::DPT_DUAL_PWM &&
        !(st.en && tick && at_reload)) |=> !timer_irq)
        else $error("interrupt from shared pin in dual PWM");

    AST_FLAG_HOLD: assert property ((st.cap_flag &&
        !(st.en && tick && at_reload) && !done) |=> st.cap_flag)
        else $error("capture flag lost without a clear event");
endmodule
`default_nettype wire
